// file: dcs_pkg.sv
// Shared constants, types and register map of the two-channel input evaluator.
// Assumes a 100 MHz system clock and 32-bit Avalon-MM access.
package dcs_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned STEP_MS     = 10;
	localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;

	// Synchronous time limits in 10 ms steps
	localparam logic [11:0] ESTOP_SYNC_MAX = 12'hbb8;
	localparam logic [11:0] SOL_SYNC_MAX   = 12'h12c;
	localparam logic [11:0] LGRID_SYNC_MAX = 12'h032;
	localparam logic [11:0] SYNC_MIN       = 12'h001;

	// Register byte offsets
	localparam logic [4:0] OFS_CTRL    = 5'h00;
	localparam logic [4:0] OFS_SYNC    = 5'h04;
	localparam logic [4:0] OFS_STATUS  = 5'h08;
	localparam logic [4:0] OFS_IRQ_STS = 5'h0c;
	localparam logic [4:0] OFS_IRQ_MSK = 5'h10;

	// Control field positions
	localparam int CTRL_PRESET_LSB = 0;
	localparam int CTRL_MODE_LSB   = 2;
	localparam int CTRL_LOCK_BIT   = 4;
	localparam int CTRL_RUN_BIT    = 5;

	// Reset values
	localparam logic [11:0] SYNC_RST    = 12'h000;
	localparam logic [3:0]  IRQ_MSK_RST = 4'h0;

	typedef enum logic [1:0] {
		PRE_ESTOP,
		PRE_SOLENOID,
		PRE_LIGHT_GRID,
		PRE_SPARE
	} dcs_preset_e;

	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_EQUIV,
		MODE_DISCREP,
		MODE_SPARE
	} dcs_mode_e;

	typedef enum logic [2:0] {
		ST_START,
		ST_LOCK,
		ST_OFF,
		ST_WAIT,
		ST_ON,
		ST_DROP,
		ST_FAULT
	} dcs_state_e;

	typedef struct packed {
		logic        run;
		logic        lock;
		dcs_mode_e   mode;
		dcs_preset_e preset;
	} dcs_cfg_s;

	// Interrupt sources: release fall, sequence error, sync error, release rise
	typedef struct packed {
		logic rel_fall;
		logic seq_err;
		logic sync_err;
		logic rel_rise;
	} dcs_evt_s;

endpackage

// file: dcs_in_sync.sv
// Three-stage synchroniser for one safety input pin.
// Assumes an asynchronous pin; output moves only when stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module dcs_in_sync (
	// System
	input  wire logic clk_sys,
	input  wire logic rst,
	// Pin and result
	input  wire logic pin,
	output var  logic level_q
);
	logic [2:0] sr_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sr_q <= 3'h0;
		end else begin
			sr_q <= {sr_q[1:0], pin};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			level_q <= 1'b0;
		end else if (sr_q[1] == sr_q[2]) begin
			level_q <= sr_q[2];
		end
	end
endmodule // dcs_in_sync
`default_nettype wire

// file: dcs_step_tick.sv
// Step tick generator: one pulse per synchronous-time step.
// Assumes clr held high restarts the step phase.
`timescale 1ns/1ns
`default_nettype none
module dcs_step_tick #(
	parameter int unsigned STEP_CYCLES = dcs_pkg::STEP_CYCLES
) (
	// System
	input  wire logic clk_sys,
	input  wire logic rst,
	// Control and tick
	input  wire logic clr,
	output var  logic tick_q
);
	logic [31:0] cnt_q;

	always_ff @(posedge clk_sys) begin
		if (rst || clr) begin
			cnt_q  <= 32'h0;
			tick_q <= 1'b0;
		end else if (cnt_q == STEP_CYCLES - 1) begin
			cnt_q  <= 32'h0;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 32'h1;
			tick_q <= 1'b0;
		end
	end
endmodule // dcs_step_tick
`default_nettype wire

// file: dcs_eval.sv
// Two-channel safety input evaluator with Avalon-MM register access.
// Assumes asynchronous input pins and a 100 MHz synchronous-reset clock domain.
//
// Overview of operation
// - Emergency stop sync time is zero (off) or 10 to 30000 ms.
// - With lock, release only after both inputs rise within sync time.
// - With lock, inputs already high at start keep release inactive.
// - Startup lock is off after reset; software may enable it.
// - Outputs are release, synchronous time error and sequence error.
// - Solenoid sync time always active, 10 to 3000 ms, no disable.
// - Solenoid release is high exactly while the evaluation is high.
// - Light grid forces two-channel equivalent, no single channel.
// - Light grid sync time is zero (off) or 10 to 500 ms.
// - Error output rises on invalid combination or order of inputs.
`timescale 1ns/1ns
`default_nettype none
module dcs_eval #(
	parameter int unsigned STEP_CYCLES = dcs_pkg::STEP_CYCLES
) (
	// System
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	// Safety inputs
	input  wire logic        in_ch1,
	input  wire logic        in_ch2,
	// Evaluation outputs
	output var  logic        release_q,
	output var  logic        sync_err_q,
	output var  logic        seq_err_q,
	// Interrupt
	output var  logic        irq_q
);
	////////////////////////////////////////////////////////////////////////////////

	function automatic dcs_pkg::dcs_mode_e legal_mode(input dcs_pkg::dcs_preset_e p,
		input dcs_pkg::dcs_mode_e m);
		legal_mode = m;
		if (m == dcs_pkg::MODE_SPARE) begin
			legal_mode = dcs_pkg::MODE_EQUIV;
		end
		if (p == dcs_pkg::PRE_LIGHT_GRID) begin
			legal_mode = dcs_pkg::MODE_EQUIV;
		end else if (p == dcs_pkg::PRE_SOLENOID && m == dcs_pkg::MODE_SINGLE) begin
			legal_mode = dcs_pkg::MODE_EQUIV;
		end
	endfunction

	function automatic logic [11:0] sync_limit(input dcs_pkg::dcs_preset_e p,
		input logic [11:0] raw);
		logic [11:0] mx;
		mx = dcs_pkg::ESTOP_SYNC_MAX;
		case (p)
			dcs_pkg::PRE_SOLENOID:   mx = dcs_pkg::SOL_SYNC_MAX;
			dcs_pkg::PRE_LIGHT_GRID: mx = dcs_pkg::LGRID_SYNC_MAX;
			default:                 mx = dcs_pkg::ESTOP_SYNC_MAX;
		endcase
		sync_limit = (raw > mx) ? mx : raw;
		if (p == dcs_pkg::PRE_SOLENOID && raw == 12'h000) begin
			sync_limit = dcs_pkg::SYNC_MIN;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [1:0] pin_w;
	logic [1:0] lvl_w;

	assign pin_w = {in_ch2, in_ch1};

	for (genvar gi = 0; gi < 2; gi++) begin : g_sync
		dcs_in_sync u_sync (
			.clk_sys (clk_sys),
			.rst     (rst),
			.pin     (pin_w[gi]),
			.level_q (lvl_w[gi])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	dcs_pkg::dcs_cfg_s cfg_q;
	logic [11:0]       sync_raw_q;
	dcs_pkg::dcs_evt_s irq_sts_q;
	dcs_pkg::dcs_evt_s irq_msk_q;
	logic              wait_q;
	logic [31:0]       rdata_q;
	logic              acc_w;
	logic              wr_w;
	logic              cfg_wr_w;

	dcs_pkg::dcs_mode_e mode_w;
	logic [11:0]        lim_w;

	assign mode_w   = legal_mode(cfg_q.preset, cfg_q.mode);
	assign lim_w    = sync_limit(cfg_q.preset, sync_raw_q);
	assign acc_w    = (read || write) && !wait_q;
	assign wr_w     = write && !wait_q;
	assign cfg_wr_w = wr_w && address == dcs_pkg::OFS_CTRL;

	assign waitrequest = wait_q;
	assign readdata    = rdata_q;

	// One wait cycle per access; request completes when waitrequest is low
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !((read || write) && wait_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_q <= '{run: 1'b0, lock: 1'b0, mode: dcs_pkg::MODE_EQUIV,
				preset: dcs_pkg::PRE_ESTOP};
		end else if (cfg_wr_w) begin
			cfg_q.preset <= (writedata[dcs_pkg::CTRL_PRESET_LSB +: 2] == 2'h3) ?
				dcs_pkg::PRE_ESTOP :
				dcs_pkg::dcs_preset_e'(writedata[dcs_pkg::CTRL_PRESET_LSB +: 2]);
			cfg_q.mode   <= dcs_pkg::dcs_mode_e'(writedata[dcs_pkg::CTRL_MODE_LSB +: 2]);
			cfg_q.lock   <= writedata[dcs_pkg::CTRL_LOCK_BIT];
			cfg_q.run    <= writedata[dcs_pkg::CTRL_RUN_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync_raw_q <= dcs_pkg::SYNC_RST;
		end else if (wr_w && address == dcs_pkg::OFS_SYNC) begin
			sync_raw_q <= writedata[11:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_msk_q <= dcs_pkg::IRQ_MSK_RST;
		end else if (wr_w && address == dcs_pkg::OFS_IRQ_MSK) begin
			irq_msk_q <= writedata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel evaluation

	logic               ch_a;
	logic               ch_b;
	logic               both_hi;
	logic               both_lo;
	logic               mon_w;
	logic               tick_w;
	logic [11:0]        wcnt_q;
	logic               tmo_w;
	dcs_pkg::dcs_state_e st_q;
	dcs_pkg::dcs_state_e st_d;
	logic               sync_ev;
	logic               seq_ev;

	// Discrepant mode inverts channel two; single mode mirrors channel one
	always_comb begin
		ch_a = lvl_w[0];
		case (mode_w)
			dcs_pkg::MODE_SINGLE:  ch_b = lvl_w[0];
			dcs_pkg::MODE_DISCREP: ch_b = !lvl_w[1];
			default:               ch_b = lvl_w[1];
		endcase
	end

	assign both_hi = ch_a && ch_b;
	assign both_lo = !ch_a && !ch_b;
	assign mon_w   = lim_w != 12'h000;
	assign tmo_w   = mon_w && wcnt_q >= lim_w;

	dcs_step_tick #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_tick (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clr     (st_q != dcs_pkg::ST_WAIT),
		.tick_q  (tick_w)
	);

	// Elapsed 10 ms steps while the channels disagree
	always_ff @(posedge clk_sys) begin
		if (rst || st_q != dcs_pkg::ST_WAIT) begin
			wcnt_q <= 12'h000;
		end else if (tick_w && wcnt_q != 12'hfff) begin
			wcnt_q <= wcnt_q + 12'h001;
		end
	end

	always_comb begin
		st_d    = st_q;
		sync_ev = 1'b0;
		seq_ev  = 1'b0;
		case (st_q)
			dcs_pkg::ST_START: begin
				if (!cfg_q.run) begin
					st_d = dcs_pkg::ST_START;
				end else if (cfg_q.lock && both_hi) begin
					st_d = dcs_pkg::ST_LOCK;
				end else if (both_hi) begin
					st_d = dcs_pkg::ST_ON;
				end else if (!both_lo) begin
					st_d = dcs_pkg::ST_WAIT;
				end else begin
					st_d = dcs_pkg::ST_OFF;
				end
			end
			dcs_pkg::ST_LOCK: begin
				if (both_lo) begin
					st_d = dcs_pkg::ST_OFF;
				end
			end
			dcs_pkg::ST_OFF: begin
				if (both_hi) begin
					st_d = dcs_pkg::ST_ON;
				end else if (!both_lo) begin
					st_d = dcs_pkg::ST_WAIT;
				end
			end
			dcs_pkg::ST_WAIT: begin
				if (tmo_w) begin
					st_d    = dcs_pkg::ST_FAULT;
					sync_ev = 1'b1;
				end else if (both_hi) begin
					st_d = dcs_pkg::ST_ON;
				end else if (both_lo) begin
					st_d = dcs_pkg::ST_OFF;
				end
			end
			dcs_pkg::ST_ON: begin
				if (!both_hi) begin
					st_d = dcs_pkg::ST_DROP;
				end
			end
			dcs_pkg::ST_DROP: begin
				if (both_lo) begin
					st_d = dcs_pkg::ST_OFF;
				end else if (both_hi) begin
					st_d   = dcs_pkg::ST_FAULT;
					seq_ev = 1'b1;
				end
			end
			dcs_pkg::ST_FAULT: begin
				if (both_lo) begin
					st_d = dcs_pkg::ST_OFF;
				end
			end
			default: st_d = dcs_pkg::ST_START;
		endcase
		if (cfg_wr_w) begin
			st_d    = dcs_pkg::ST_START;
			sync_ev = 1'b0;
			seq_ev  = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= dcs_pkg::ST_START;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			release_q <= 1'b0;
		end else begin
			release_q <= st_d == dcs_pkg::ST_ON;
		end
	end

	// Errors hold until both channels return to the safe state or the control register is written
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync_err_q <= 1'b0;
			seq_err_q  <= 1'b0;
		end else begin
			sync_err_q <= sync_ev || (sync_err_q && st_d == dcs_pkg::ST_FAULT);
			seq_err_q  <= seq_ev || (seq_err_q && st_d == dcs_pkg::ST_FAULT);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts

	dcs_pkg::dcs_evt_s evt_w;
	dcs_pkg::dcs_evt_s clr_w;
	dcs_pkg::dcs_evt_s sts_d;

	assign evt_w = '{
		rel_fall: st_q == dcs_pkg::ST_ON && st_d != dcs_pkg::ST_ON,
		seq_err:  seq_ev,
		sync_err: sync_ev,
		rel_rise: st_d == dcs_pkg::ST_ON && st_q != dcs_pkg::ST_ON
	};
	assign clr_w = (wr_w && address == dcs_pkg::OFS_IRQ_STS) ? writedata[3:0] : 4'h0;
	assign sts_d = (irq_sts_q & ~clr_w) | evt_w;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_sts_q <= 4'h0;
		end else begin
			irq_sts_q <= sts_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(sts_d & irq_msk_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_q <= 32'h0;
		end else if ((read || write) && wait_q) begin
			case (address)
				dcs_pkg::OFS_CTRL:    rdata_q <= {26'h0, cfg_q.run, cfg_q.lock,
					mode_w, cfg_q.preset};
				dcs_pkg::OFS_SYNC:    rdata_q <= {20'h0, sync_raw_q};
				dcs_pkg::OFS_STATUS:  rdata_q <= {24'h0, st_q, lvl_w, seq_err_q,
					sync_err_q, release_q};
				dcs_pkg::OFS_IRQ_STS: rdata_q <= {28'h0, irq_sts_q};
				dcs_pkg::OFS_IRQ_MSK: rdata_q <= {28'h0, irq_msk_q};
				default:              rdata_q <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	chk_estop_sync_range: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_q.preset == dcs_pkg::PRE_ESTOP |-> lim_w <= dcs_pkg::ESTOP_SYNC_MAX)
		else $error("estop sync limit out of range");

	chk_lock_start_high: assert property (@(posedge clk_sys) disable iff (rst)
		st_q == dcs_pkg::ST_START && cfg_q.run && cfg_q.lock && both_hi && !cfg_wr_w
		|=> !release_q ##1 (!release_q || $past(both_lo, 2) == 1'b0))
		else $error("release given with inputs high at locked start");

	chk_lock_rise_path: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(release_q) && cfg_q.lock |-> $past(st_q) != dcs_pkg::ST_LOCK)
		else $error("release left lock state directly");

	chk_lock_default_off: assert property (@(posedge clk_sys)
		rst |=> !cfg_q.lock && !release_q)
		else $error("startup lock not off after reset");

	chk_sol_sync_active: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_q.preset == dcs_pkg::PRE_SOLENOID |->
		lim_w >= dcs_pkg::SYNC_MIN && lim_w <= dcs_pkg::SOL_SYNC_MAX)
		else $error("solenoid sync limit out of range");

	chk_sol_release_eval: assert property (@(posedge clk_sys) disable iff (rst)
		st_q == dcs_pkg::ST_ON && !cfg_wr_w && both_hi |=> release_q)
		else $error("release low while evaluation high");

	chk_lgrid_mode_equiv: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_q.preset == dcs_pkg::PRE_LIGHT_GRID |-> mode_w == dcs_pkg::MODE_EQUIV)
		else $error("light grid mode not equivalent");

	chk_lgrid_sync_range: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_q.preset == dcs_pkg::PRE_LIGHT_GRID |-> lim_w <= dcs_pkg::LGRID_SYNC_MAX)
		else $error("light grid sync limit out of range");

	chk_seq_err_set: assert property (@(posedge clk_sys) disable iff (rst)
		st_q == dcs_pkg::ST_DROP && both_hi && !cfg_wr_w |=> seq_err_q && !release_q)
		else $error("sequence error not raised");

	chk_sol_no_single: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_q.preset == dcs_pkg::PRE_SOLENOID |-> mode_w != dcs_pkg::MODE_SINGLE)
		else $error("solenoid in single mode");

	chk_sync_timeout: assert property (@(posedge clk_sys) disable iff (rst)
		st_q == dcs_pkg::ST_WAIT && tmo_w && !cfg_wr_w |=> sync_err_q && !release_q
		##1 (sync_err_q || $past(both_lo)))
		else $error("sync timeout not flagged");

	chk_outputs_exclusive: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_err_q || seq_err_q) |-> !release_q)
		else $error("release high with error");

endmodule // dcs_eval
`default_nettype wire

// file: dcs_sw_model.sv
// Behavioural two-channel safety switch facing the evaluator inputs.
// Assumes commands change just after a rising edge; channel 2 lags by skew cycles.
`timescale 1ns/1ns
`default_nettype none
module dcs_sw_model (
	// System
	input  wire logic       clk_sys,
	// Commands
	input  wire logic       cmd_a,
	input  wire logic       cmd_b,
	input  wire logic [7:0] skew,
	// Contacts, one for each channel of the two-channel evaluator input
	output wire logic       in_ch1,
	output wire logic       in_ch2
);
	logic       ch1_q = 1'b0;
	logic       ch2_q = 1'b0;
	logic [7:0] cnt_q = 8'h00;

	assign in_ch1 = ch1_q;
	assign in_ch2 = ch2_q;

	// Channel 2 follows its command only after the skew has run out
	always @(posedge clk_sys) begin
		ch1_q <= cmd_a;
		if (cmd_b == ch2_q) begin
			cnt_q <= 8'h00;
		end else if (cnt_q >= skew) begin
			ch2_q <= cmd_b;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule // dcs_sw_model
`default_nettype wire

// file: test_dual_channel_safety_input_eval.sv
// Self-checking bench for the two-channel evaluator with a switch model.
// Assumes dcs_pkg, dcs_eval and dcs_sw_model are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
module test_dual_channel_safety_input_eval;
	localparam int unsigned STEP = 10;
	typedef struct packed {
		logic [4:0]  a;
		logic [31:0] w;
		logic [31:0] r;
	} dcs_row_s;

	logic        clk_sys   = 1'b0;
	logic        rst       = 1'b1;
	logic [4:0]  address   = 5'h00;
	logic        read      = 1'b0;
	logic        write     = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic        cmd_a     = 1'b0;
	logic        cmd_b     = 1'b0;
	logic [7:0]  skew      = 8'h00;
	logic [31:0] rd;
	wire logic [31:0] readdata;
	wire logic        waitrequest, in_ch1, in_ch2, release_q, sync_err_q, seq_err_q, irq_q;
	wire logic [3:0]  outs;
	int num_errors = 0;
	int compares   = 0;
	dcs_row_s rows [0:12] = '{
		'{dcs_pkg::OFS_CTRL, 32'h24, 32'h24}, '{dcs_pkg::OFS_CTRL, 32'h20, 32'h20},
		'{dcs_pkg::OFS_CTRL, 32'h28, 32'h28}, '{dcs_pkg::OFS_CTRL, 32'h27, 32'h24},
		'{dcs_pkg::OFS_CTRL, 32'h2c, 32'h24}, '{dcs_pkg::OFS_CTRL, 32'h31, 32'h35},
		'{dcs_pkg::OFS_CTRL, 32'h29, 32'h29}, '{dcs_pkg::OFS_CTRL, 32'h2a, 32'h26},
		'{dcs_pkg::OFS_SYNC, 32'hbb8, 32'hbb8}, '{dcs_pkg::OFS_SYNC, 32'hffffffff, 32'hfff},
		'{dcs_pkg::OFS_IRQ_MSK, 32'hffff, 32'hf}, '{5'h14, 32'h5, 32'h0},
		'{dcs_pkg::OFS_IRQ_MSK, 32'h0, 32'h0}};

	assign outs = {irq_q, seq_err_q, sync_err_q, release_q};
	always #5 clk_sys = ~clk_sys;

	dcs_eval #(.STEP_CYCLES(STEP)) dut (.clk_sys(clk_sys), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .in_ch1(in_ch1), .in_ch2(in_ch2), .release_q(release_q),
		.sync_err_q(sync_err_q), .seq_err_q(seq_err_q), .irq_q(irq_q));
	dcs_sw_model sw (.clk_sys(clk_sys), .cmd_a(cmd_a), .cmd_b(cmd_b), .skew(skew),
		.in_ch1(in_ch1), .in_ch2(in_ch2));

	////////////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task check_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: read %h want %h", $time, got, exp);
		end
	endtask

	task check_outs(input logic [3:0] exp);
		compares++;
		if (outs !== exp) begin
			num_errors++;
			$display("unexpected at %0t: outputs %b want %b", $time, outs, exp);
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		address   <= a;
		write     <= wr;
		read      <= ~wr;
		writedata <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		if (n >= 50) begin
			num_errors++;
			$display("unexpected at %0t: bus timeout", $time);
		end
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	task rd_chk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check_reg(rd, exp);
	endtask

	task cfg(input logic [1:0] p, input logic [1:0] m, input logic l);
		bus(1'b1, dcs_pkg::OFS_CTRL, {26'h0, 1'b1, l, m, p});
	endtask

	task set_in(input logic a, input logic b, input logic [7:0] s);
		@(posedge clk_sys);
		cmd_a <= a;
		cmd_b <= b;
		skew  <= s;
	endtask

	task hold(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task wait_outs(input logic [3:0] exp, input int max);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (outs !== exp && n < max);
		check_outs(exp);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		$display("unexpected at %0t: watchdog", $time);
		report_and_stop;
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		hold(1);
		check_outs(4'h0);
		rd_chk(dcs_pkg::OFS_CTRL, 32'h4);
		rd_chk(dcs_pkg::OFS_SYNC, 32'h0);
		rd_chk(dcs_pkg::OFS_IRQ_MSK, 32'h0);
		rd_chk(dcs_pkg::OFS_STATUS, 32'h0);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].w);
			rd_chk(rows[i].a, rows[i].r);
		end
		// Sync time of 30 cycles, well above the input reaction time
		bus(1'b1, dcs_pkg::OFS_SYNC, 32'h3);
		cfg(2'h0, 2'h1, 1'b0);
		bus(1'b1, dcs_pkg::OFS_IRQ_MSK, 32'h1);
		set_in(1'b1, 1'b1, 8'h00);
		wait_outs(4'b1001, 40);
		bus(1'b1, dcs_pkg::OFS_IRQ_STS, 32'h1);
		wait_outs(4'b0001, 10);
		set_in(1'b0, 1'b1, 8'h00);
		wait_outs(4'b0000, 20);
		rd_chk(dcs_pkg::OFS_IRQ_STS, 32'h8);
		bus(1'b1, dcs_pkg::OFS_IRQ_MSK, 32'h8);
		wait_outs(4'b1000, 10);
		bus(1'b1, dcs_pkg::OFS_IRQ_MSK, 32'h0);
		bus(1'b1, dcs_pkg::OFS_IRQ_STS, 32'hf);
		set_in(1'b1, 1'b1, 8'h00);
		wait_outs(4'b0100, 20);
		set_in(1'b0, 1'b0, 8'h00);
		wait_outs(4'b0000, 20);
		rd_chk(dcs_pkg::OFS_IRQ_STS, 32'h4);
		bus(1'b1, dcs_pkg::OFS_IRQ_STS, 32'hf);
		set_in(1'b1, 1'b0, 8'h00);
		hold(15);
		check_outs(4'b0000);
		wait_outs(4'b0010, 60);
		set_in(1'b0, 1'b0, 8'h00);
		wait_outs(4'b0000, 20);
		set_in(1'b1, 1'b1, 8'd60);
		wait_outs(4'b0010, 80);
		hold(60);
		check_outs(4'b0010);
		set_in(1'b0, 1'b0, 8'h00);
		wait_outs(4'b0000, 20);
		// Startup lock
		set_in(1'b1, 1'b1, 8'h00);
		hold(10);
		cfg(2'h0, 2'h1, 1'b1);
		hold(60);
		check_outs(4'b0000);
		set_in(1'b0, 1'b0, 8'h00);
		hold(20);
		set_in(1'b1, 1'b1, 8'd10);
		wait_outs(4'b0001, 40);
		set_in(1'b0, 1'b0, 8'h00);
		wait_outs(4'b0000, 20);
		// Sync time zero: off for emergency stop and light grid, one step for solenoid
		for (int p = 0; p < 3; p++) begin
			bus(1'b1, dcs_pkg::OFS_SYNC, 32'h0);
			cfg(p[1:0], 2'h1, 1'b0);
			set_in(1'b1, 1'b0, 8'h00);
			hold(60);
			check_outs((p == 1) ? 4'b0010 : 4'b0000);
			set_in(1'b0, 1'b0, 8'h00);
			wait_outs(4'b0000, 20);
		end
		// Light grid limit clamps to 50 steps
		bus(1'b1, dcs_pkg::OFS_SYNC, 32'hff);
		cfg(2'h2, 2'h1, 1'b0);
		set_in(1'b1, 1'b0, 8'h00);
		hold(400);
		check_outs(4'b0000);
		wait_outs(4'b0010, 200);
		set_in(1'b0, 1'b0, 8'h00);
		wait_outs(4'b0000, 20);
		cfg(2'h0, 2'h0, 1'b0);
		set_in(1'b1, 1'b0, 8'h00);
		wait_outs(4'b0001, 20);
		set_in(1'b0, 1'b0, 8'h00);
		wait_outs(4'b0000, 20);
		bus(1'b1, dcs_pkg::OFS_SYNC, 32'h3);
		cfg(2'h0, 2'h2, 1'b0);
		set_in(1'b1, 1'b0, 8'h00);
		wait_outs(4'b0001, 20);
		set_in(1'b1, 1'b1, 8'h00);
		wait_outs(4'b0000, 20);
		// Reset in mid-run
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		hold(1);
		check_outs(4'b0000);
		rd_chk(dcs_pkg::OFS_CTRL, 32'h4);
		report_and_stop;
	end
endmodule // test_dual_channel_safety_input_eval
`default_nettype wire
